/* File: apd_pkg.sv */
package apd_pkg;
   // ==========================================================
   // Dimensions
   localparam int APD_NUM_PARAM   = 8;
   localparam int APD_NUM_DEBUG   = 64;
   localparam int APD_WORD_W      = 64;
   localparam int APD_SEG_W       = 10;
   localparam int APD_ADDR_W      = 12;
   // ==========================================================
   // Register map (byte addresses, 32-bit words)
   // Parameters: 0x000 + 8*n (low word), +4 (high word)
   // Debug ports: 0x400 + 8*n (low word), +4 (high word)
   localparam logic [11:0] APD_PARAM_BASE  = 12'h000;
   localparam logic [11:0] APD_SEG0_ADDR   = 12'h040;
   localparam logic [11:0] APD_SEG1_ADDR   = 12'h044;
   localparam logic [11:0] APD_CTRL_ADDR   = 12'h048;
   localparam logic [11:0] APD_STAT_ADDR   = 12'h04c;
   localparam logic [11:0] APD_DEBUG_BASE  = 12'h400;
   // Control / status fields
   localparam int          APD_CTRL_RUN_BIT = 0;
   localparam int          APD_STAT_RUN_BIT = 0;
   localparam int          APD_STAT_RSE_BIT = 1;
   // Reset values
   localparam logic [9:0]  APD_SEG_RST     = 10'h000;
   localparam logic [31:0] APD_UNMAPPED    = 32'h0000_0000;
endpackage : apd_pkg

/* File: apd_alg_param_debug_regs.sv */
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
module apd_alg_param_debug_regs
   import apd_pkg::*;
(
   // Clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // Wishbone slave
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [apd_pkg::APD_ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   // Algorithm side
   input  wire logic [apd_pkg::APD_NUM_PARAM*apd_pkg::APD_WORD_W-1:0]
                                              param_reg_default_i,
   input  wire logic                          param_rst_en_i,
   input  wire logic [apd_pkg::APD_NUM_DEBUG*apd_pkg::APD_WORD_W-1:0]
                                              debug_out_port_i,
   input  wire logic                          alg_running_i,
   output logic [apd_pkg::APD_NUM_PARAM*apd_pkg::APD_WORD_W-1:0]
                                              param_reg_value_o,
   output logic [apd_pkg::APD_SEG_W-1:0]      segment_offset_bank0_o,
   output logic [apd_pkg::APD_SEG_W-1:0]      segment_offset_bank1_o,
   output logic                               alg_go_o
);
   import apd_pkg::*;

   // ==========================================================
   // Bus decode
   logic        req;
   logic        wr_stb;
   logic        host_lock;
   logic        seg_wr_ok;
   logic        seg0_wr;
   logic        seg1_wr;
   logic        ctrl_wr;
   logic        dbg_hit;
   logic        par_hit;
   logic [31:0] rd_next;
   logic [31:0] rd_dbg;
   logic [31:0] rd_par;
   logic [31:0] rd_misc;
   logic [31:0] wmask;

   // New request only when not already acknowledging
   assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Writes to run-sensitive state are blocked while running;
   // refused writes are still acknowledged so the master never stalls
   assign host_lock = alg_running_i;
   assign wr_stb = req && wb_we_i;
   // Offsets are 10 bits wide, so both low lanes must be written
   assign seg_wr_ok = wr_stb && !host_lock && wb_sel_i[0] && wb_sel_i[1];
   // Per-bank offset strobes
   assign seg0_wr = seg_wr_ok && (wb_adr_i == APD_SEG0_ADDR);
   assign seg1_wr = seg_wr_ok && (wb_adr_i == APD_SEG1_ADDR);
   // Run control stays writable while running so software can stop it
   assign ctrl_wr = wr_stb && (wb_adr_i == APD_CTRL_ADDR) && wb_sel_i[0];

   // Byte-lane mask from select
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
      end
   end

   // Lane merge: bytes without a select keep their old value
   function automatic logic [31:0] merge_lanes(
      input logic [31:0] old_w,
      input logic [31:0] new_w,
      input logic [31:0] mask);
      return (old_w & ~mask) | (new_w & mask);
   endfunction

   // ==========================================================
   // Parameter registers, one per generate entry
   genvar g;
   generate
      for (g = 0; g < APD_NUM_PARAM; g++) begin : g_param
         // Word addresses of this entry
         localparam logic [11:0] LO = APD_PARAM_BASE + 12'(g * 8);
         localparam logic [11:0] HI = LO + 12'h004;
         // Per-entry strobes and storage
         logic        lo_wr;
         logic        hi_wr;
         logic [63:0] value_reg;

         // Word strobes; refused while the algorithm runs
         assign lo_wr = wr_stb && !host_lock && (wb_adr_i == LO);
         assign hi_wr = wr_stb && !host_lock && (wb_adr_i == HI);
         // Default load or hold on reset, lane-merged host write
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               if (param_rst_en_i) begin
                  value_reg <= param_reg_default_i[g*64 +: 64];
               end
            end else begin
               if (lo_wr) begin
                  value_reg[31:0] <=
                     merge_lanes(value_reg[31:0], wb_dat_i, wmask);
               end
               if (hi_wr) begin
                  value_reg[63:32] <=
                     merge_lanes(value_reg[63:32], wb_dat_i, wmask);
               end
            end
         end

         // Live value straight from the flops to the algorithm
         assign param_reg_value_o[g*64 +: 64] = value_reg;
      end
   endgenerate

   // ==========================================================
   // Segment offsets, changed only between runs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         segment_offset_bank0_o <= APD_SEG_RST;
      end else if (seg0_wr) begin
         segment_offset_bank0_o <= wb_dat_i[APD_SEG_W-1:0];
      end
   end

   // Second bank has its own word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         segment_offset_bank1_o <= APD_SEG_RST;
      end else if (seg1_wr) begin
         segment_offset_bank1_o <= wb_dat_i[APD_SEG_W-1:0];
      end
   end

   // ==========================================================
   // Run request level for the algorithm controller
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alg_go_o <= 1'b0;
      end else if (ctrl_wr) begin
         alg_go_o <= wb_dat_i[APD_CTRL_RUN_BIT];
      end
   end

   // ==========================================================
   // Read multiplexer, split by region
   // Debug window: word aligned, two words per port
   assign dbg_hit = (wb_adr_i >= APD_DEBUG_BASE) &&
                    (wb_adr_i < APD_DEBUG_BASE + 12'(APD_NUM_DEBUG * 8)) &&
                    (wb_adr_i[1:0] == 2'b00);
   // Parameter window at the bottom of the map
   assign par_hit = (wb_adr_i < APD_PARAM_BASE + 12'(APD_NUM_PARAM * 8)) &&
                    (wb_adr_i[1:0] == 2'b00);

   // Debug ports, live snapshot at read time
   always_comb begin
      logic [11:0] off;
      off    = wb_adr_i - APD_DEBUG_BASE;
      rd_dbg = debug_out_port_i[{off[8:3], off[2], 5'h00} +: 32];
   end

   // Parameter words read back the value the algorithm sees
   always_comb begin
      rd_par = param_reg_value_o[{wb_adr_i[5:2], 5'h00} +: 32];
   end

   // Offsets, control and status words
   always_comb begin
      rd_misc = APD_UNMAPPED;
      case (wb_adr_i)
         APD_SEG0_ADDR: rd_misc = 32'(segment_offset_bank0_o);
         APD_SEG1_ADDR: rd_misc = 32'(segment_offset_bank1_o);
         APD_CTRL_ADDR: rd_misc = 32'(alg_go_o);
         APD_STAT_ADDR: begin
            rd_misc[APD_STAT_RUN_BIT] = alg_running_i;
            rd_misc[APD_STAT_RSE_BIT] = param_rst_en_i;
         end
         default:       rd_misc = APD_UNMAPPED;
      endcase
   end

   // Region select; anything unmapped reads as zero
   always_comb begin
      if (dbg_hit) begin
         rd_next = rd_dbg;
      end else if (par_hit) begin
         rd_next = rd_par;
      end else begin
         rd_next = rd_misc;
      end
   end

   // ==========================================================
   // Acknowledge one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // Read data registered with the acknowledge, held until next read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= APD_UNMAPPED;
      end else if (req && !wb_we_i) begin
         wb_dat_o <= rd_next;
      end
   end

endmodule // apd_alg_param_debug_regs

/* File: apd_alg_model.sv */
`timescale 1ns/100ps
module apd_alg_model (
   // Clock, reset and live parameters
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic [511:0]  param_i,
   input  wire logic [9:0]    seg0_i,
   // Defaults and debug ports
   output logic      [511:0]  dflt_o,
   output logic      [4095:0] dbg_o
);
   localparam logic [19:0] FIXED_ADR = 20'hffc00;
   localparam logic [19:0] STRM_REL  = 20'h00010;
   logic        rst_q;
   logic [31:0] match_q;
   logic [19:0] strm_adr;
   // Tied default per register
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         dflt_o[64*i+:64] = {32'(i+1), 32'h5a5a_0000 + 32'(i)};
      end
   end
   // Reset registered once before it fans out
   always_ff @(posedge clk_i) begin
      rst_q <= rst_i;
   end
   // Parameter bit range sampled on the algorithm clock
   always_ff @(posedge clk_i) begin
      if (rst_q) begin
         match_q <= 32'h0000_0000;
      end else begin
         match_q <= param_i[63:32];
      end
   end
   // Offset drives word address bits 19..10; stream offset is relative
   assign strm_adr = {seg0_i, 10'h000} + STRM_REL;
   // Debug ports: flopped copies; 62 fixed address, 63 internal state
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 62; i++) begin
         dbg_o[64*i+:64] <= param_i[63:0] ^ 64'(i);
      end
      dbg_o[62*64+:64] <= {44'h0, FIXED_ADR};
      dbg_o[63*64+:64] <= {12'h000, strm_adr, match_q};
   end
endmodule // apd_alg_model

/* File: apd_asserts.sv */
`timescale 1ns/100ps
module apd_asserts (
   input wire logic         clk_i,
   input wire logic         rst_i,
   input wire logic         wb_cyc_i,
   input wire logic         wb_stb_i,
   input wire logic         wb_we_i,
   input wire logic         wb_ack_o,
   input wire logic         param_rst_en_i,
   input wire logic         alg_running_i,
   input wire logic [511:0] param_reg_default_i,
   input wire logic [511:0] param_reg_value_o,
   input wire logic [9:0]   segment_offset_bank0_o
);
   // ==========================================================
   // Handshake, hold and reset checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_dflt_rst;
      rst_i && param_rst_en_i;
   endsequence
   sequence s_keep_rst;
      rst_i && !param_rst_en_i;
   endsequence
   a_ack_next: assert property (s_req |=> wb_ack_o)
      else $error("no ack");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   a_param_hold: assert property (!(wb_cyc_i && wb_we_i) |=>
      $stable(param_reg_value_o)) else $error("param moved");
   a_run_param: assert property (alg_running_i |=>
      $stable(param_reg_value_o)) else $error("param in run");
   a_run_offset: assert property (alg_running_i |=>
      $stable(segment_offset_bank0_o)) else $error("offset in run");
   a_dflt_load: assert property (disable iff (1'b0) s_dflt_rst |=>
      param_reg_value_o == $past(param_reg_default_i)) else $error("dflt");
   a_dflt_keep: assert property (disable iff (1'b0) s_keep_rst |=>
      $stable(param_reg_value_o)) else $error("kept");
   a_offset_rst: assert property (disable iff (1'b0) rst_i |=>
      segment_offset_bank0_o == 10'h000 && !wb_ack_o) else $error("rst");
endmodule // apd_asserts
bind apd_alg_param_debug_regs apd_asserts u_asserts (.*);

/* File: testbench.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
$display("CHECK FAILED %0t %h %h", $time, a, b); end end
module testbench;
   import apd_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, rse = 1, run = 0, ack, go;
   logic [11:0] adr = 0;
   logic [3:0] sel = 0;
   logic [31:0] wd = 0, rd, q;
   logic [511:0] df, pv;
   logic [4095:0] dbg;
   logic [9:0] s0, s1;
   int err_count = 0, tests_run = 0;
   apd_alg_model alg (.clk_i(clk_i), .rst_i(rst_i), .param_i(pv),
      .seg0_i(s0), .dflt_o(df), .dbg_o(dbg));
   apd_alg_param_debug_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .param_reg_default_i(df),
      .param_rst_en_i(rse), .debug_out_port_i(dbg), .alg_running_i(run),
      .param_reg_value_o(pv), .segment_offset_bank0_o(s0),
      .segment_offset_bank1_o(s1), .alg_go_o(go));
   initial forever #10 clk_i = ~clk_i;
   // One classic cycle held until ack is sampled high; read data in q
   task automatic bus(logic w, logic [11:0] a, logic [31:0] d,
                      logic [3:0] s = 4'hf);
      int n = 0;
      cyc <= 1;
      we <= w;
      adr <= a;
      wd <= d;
      sel <= s;
      do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
      q = rd;
      cyc <= 0;
      @(posedge clk_i);
      if (n >= 20) err_count++;
   endtask
   task automatic rst_seq();
      rst_i <= 1;
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
   endtask
   // Defaults, lane writes, debug and unmapped reads
   task automatic t_regs();
      for (int i = 0; i < 8; i++) begin
         bus(0, 12'(8*i+4), 0);
         `CHK(q, 32'(i+1))
         `CHK(pv[64*i+:64], {32'(i+1), 32'h5a5a_0000+32'(i)})
      end
      bus(1, 12'h018, 32'hdead_beef, 4'h3);
      bus(1, 12'h01c, 32'h1111_2222);
      bus(1, 12'h000, 32'h9abc_def0);
      bus(0, 12'h018, 0);
      `CHK(q, 32'h5a5a_beef)
      bus(0, 12'h428, 0);
      `CHK(q, 32'h9abc_def5)
      bus(0, 12'h800, 0);
      `CHK(q, APD_UNMAPPED)
   endtask
   // Writes blocked while running, offsets, reset keep and reload
   task automatic t_run();
      run <= 1;
      bus(1, 12'h040, 32'h155);
      bus(1, 12'h018, 0);
      `CHK({s0, pv[255:192]}, {10'h000, 64'h1111_2222_5a5a_beef})
      run <= 0;
      bus(1, 12'h040, 32'h2aa);
      bus(1, 12'h044, 32'h3ff);
      `CHK({s0, s1}, 20'haabff)
      bus(0, 12'h044, 0);
      `CHK(q, 32'h0000_03ff)
      bus(0, 12'h5fc, 0);
      `CHK(q, 32'h000a_a810)
      bus(0, 12'h5f0, 0);
      `CHK(q, 32'h000f_fc00)
      bus(0, 12'h5f8, 0);
      `CHK(q, 32'h0000_0001)
      rse <= 0;
      rst_seq();
      `CHK({s0, pv[255:192]}, {10'h000, 64'h1111_2222_5a5a_beef})
      rse <= 1;
      rst_seq();
      `CHK(pv[255:192], 64'h0000_0004_5a5a_0003)
   endtask
   // Run control and status, control writable while running
   task automatic t_ctrl();
      bus(1, APD_CTRL_ADDR, 32'h0000_0001, 4'h1);
      `CHK(go, 1'b1)
      bus(0, APD_CTRL_ADDR, 0);
      `CHK(q, 32'h0000_0001)
      run <= 1;
      bus(0, APD_STAT_ADDR, 0);
      `CHK(q, 32'h0000_0003)
      bus(1, APD_CTRL_ADDR, 32'h0000_0000, 4'h1);
      `CHK(go, 1'b0)
      run <= 0;
   endtask
   task automatic finish_test();
      $display("Checks %0d, errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk_i);
      err_count++;
      finish_test();
   end
   initial begin
      rst_seq();
      t_regs();
      t_run();
      t_ctrl();
      finish_test();
   end
endmodule // testbench
